// ===== core/gfc_cmd_field.sv
`timescale 1ns/10ps
`default_nettype none
module gfc_cmd_field (
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   input  wire logic        wr_en_in,
   input  wire logic [1:0]  byte_en_in,
   input  wire logic [15:0] wr_data_in,
   output logic      [15:0] value_out
);
   logic [15:0] cmd_ff;
   logic [15:0] nxt_cmd;
   logic [15:0] lane_mask;

   always_comb begin
      lane_mask = {{8{byte_en_in[1]}}, {8{byte_en_in[0]}}} & gfc_pkg::CMD_WRITE_MASK;
      nxt_cmd   = (cmd_ff & ~lane_mask) | (wr_data_in & lane_mask) | gfc_pkg::CMD_FIXED_ONES;
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cmd_ff <= gfc_pkg::CMD_RESET;
      end else if (wr_en_in) begin
         cmd_ff <= nxt_cmd;
      end
   end

   assign value_out = cmd_ff;
endmodule : gfc_cmd_field
`default_nettype wire

// ===== core/gfc_pkg.sv
package gfc_pkg;
   // Configuration register byte offsets
   localparam logic [7:0]  IDENT_OFFSET      = 8'h02;
   localparam logic [7:0]  CMD_OFFSET        = 8'h04;
   // Command register layout
   localparam int          IO_EN_BIT         = 0;
   localparam int          MEM_EN_BIT        = 1;
   localparam int          BUS_MASTER_BIT    = 2;
   localparam int          SPECIAL_CYC_BIT   = 3;
   localparam int          WR_INVAL_BIT      = 4;
   localparam int          PALETTE_SNOOP_BIT = 5;
   localparam int          PARITY_RESP_BIT   = 6;
   localparam int          STEPPING_BIT      = 7;
   localparam int          SYS_ERR_BIT       = 8;
   localparam int          BACK_TO_BACK_BIT  = 9;
   localparam logic [15:0] CMD_RESET         = 16'h0004;
   localparam logic [15:0] CMD_WRITE_MASK    = 16'h0003;
   localparam logic [15:0] CMD_FIXED_ONES    = 16'h0004;
   // Arbitrary neutral identity value
   localparam logic [15:0] IDENT_DEFAULT     = 16'h0A5C;
   localparam logic [15:0] ZERO16            = 16'h0000;
   localparam logic [1:0]  ZERO2             = 2'h0;
endpackage : gfc_pkg

// ===== core/gfc_regs.sv
// Summary of operation
// - Identity word is read-only, writes ignored
// - Back-to-back enable bit reads zero always
// - System error enable bit fixed zero
// - Stepping control bit fixed zero
// - Parity response bit zero, parity ignored
// - Palette snoop bit fixed zero
// - Write-and-invalidate bit fixed zero
// - Special cycle bit zero, never respond
// - Bus master bit fixed one
// - Memory enable writable, resets zero, gates claim
// - I/O enable writable, resets zero, gates claim
// - Reached only via config, graphics mode only
`timescale 1ns/10ps
`default_nettype none
module gfc_regs #(
   parameter logic [15:0] IDENT_VALUE = gfc_pkg::IDENT_DEFAULT
) (
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   input  wire logic        gfx_mode_in,
   input  wire logic        cfg_wr_in,
   input  wire logic        cfg_rd_in,
   input  wire logic [7:0]  cfg_addr_in,
   input  wire logic [1:0]  cfg_byte_en_in,
   input  wire logic [15:0] cfg_wr_data_in,
   input  wire logic        mem_decode_in,
   input  wire logic        io_decode_in,
   input  wire logic        special_cycle_in,
   output logic      [15:0] cfg_rd_data_out,
   output logic             cfg_hit_out,
   output logic             mem_claim_out,
   output logic             io_claim_out,
   output logic             bus_master_enable_out,
   output logic             special_cycle_claim_out,
   output logic             parity_response_enable_out
);
   logic [15:0] cmd_value;
   logic [15:0] rd_data_ff;
   logic        gfx_mode_meta_ff;
   logic        gfx_mode_ff;
   logic        sel_ident;
   logic        sel_cmd;
   logic        cmd_write;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         gfx_mode_meta_ff <= 1'b0;
         gfx_mode_ff      <= 1'b0;
      end else begin
         gfx_mode_meta_ff <= gfx_mode_in;
         gfx_mode_ff      <= gfx_mode_meta_ff;
      end
   end

   assign sel_ident = gfx_mode_ff && (cfg_addr_in == gfc_pkg::IDENT_OFFSET);
   assign sel_cmd   = gfx_mode_ff && (cfg_addr_in == gfc_pkg::CMD_OFFSET);
   assign cmd_write = cfg_wr_in && sel_cmd;
   assign cfg_hit_out = (cfg_wr_in || cfg_rd_in) && (sel_ident || sel_cmd);

   gfc_cmd_field u_cmd (
      .clock_in   (clock_in),
      .resetn_in  (resetn_in),
      .wr_en_in   (cmd_write),
      .byte_en_in (cfg_byte_en_in),
      .wr_data_in (cfg_wr_data_in),
      .value_out  (cmd_value)
   );

   // Read data register; identity never written
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_data_ff <= gfc_pkg::ZERO16;
      end else if (cfg_rd_in) begin
         if (sel_ident) begin
            rd_data_ff <= IDENT_VALUE;
         end else if (sel_cmd) begin
            rd_data_ff <= cmd_value;
         end else begin
            rd_data_ff <= gfc_pkg::ZERO16;
         end
      end
   end

   assign cfg_rd_data_out = rd_data_ff;
   assign mem_claim_out = mem_decode_in && cmd_value[gfc_pkg::MEM_EN_BIT];
   assign io_claim_out  = io_decode_in && cmd_value[gfc_pkg::IO_EN_BIT];
   assign bus_master_enable_out = cmd_value[gfc_pkg::BUS_MASTER_BIT];
   assign special_cycle_claim_out = special_cycle_in && cmd_value[gfc_pkg::SPECIAL_CYC_BIT];
   assign parity_response_enable_out = cmd_value[gfc_pkg::PARITY_RESP_BIT];

   ident_read_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      cfg_rd_in && sel_ident |=> cfg_rd_data_out == IDENT_VALUE)
      else $error("identity read wrong");
   back_to_back_zero_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !cmd_value[gfc_pkg::BACK_TO_BACK_BIT])
      else $error("back-to-back bit set");
   serr_zero_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !cmd_value[gfc_pkg::SYS_ERR_BIT])
      else $error("system error bit set");
   step_zero_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !cmd_value[gfc_pkg::STEPPING_BIT])
      else $error("stepping bit set");
   parity_off_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !parity_response_enable_out)
      else $error("parity response on");
   snoop_zero_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !cmd_value[gfc_pkg::PALETTE_SNOOP_BIT])
      else $error("snoop bit set");
   mwi_zero_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !cmd_value[gfc_pkg::WR_INVAL_BIT])
      else $error("write invalidate bit set");
   special_none_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !special_cycle_claim_out)
      else $error("special cycle claimed");
   master_on_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      bus_master_enable_out)
      else $error("bus master off");
   mem_write_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      cmd_write && cfg_byte_en_in[0] |=>
      cmd_value[gfc_pkg::MEM_EN_BIT] == $past(cfg_wr_data_in[gfc_pkg::MEM_EN_BIT]))
      else $error("memory enable not written");
   io_gate_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      io_claim_out |-> cmd_value[gfc_pkg::IO_EN_BIT] && io_decode_in)
      else $error("io claimed while disabled");
   rsvd_zero_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      cmd_value[15:10] == 6'h00)
      else $error("reserved bits set");
   mode_gate_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !gfx_mode_ff |-> !cfg_hit_out)
      else $error("hit outside graphics mode");
   io_write_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      cmd_write && cfg_byte_en_in[0] |=>
      cmd_value[gfc_pkg::IO_EN_BIT] == $past(cfg_wr_data_in[gfc_pkg::IO_EN_BIT]))
      else $error("io enable not written");
   mem_gate_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      mem_claim_out |-> cmd_value[gfc_pkg::MEM_EN_BIT] && mem_decode_in)
      else $error("memory claimed while disabled");
   cmd_guard_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !cmd_write |=> $stable(cmd_value))
      else $error("command changed without write");
   upper_lane_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      cmd_write && !cfg_byte_en_in[0] |=> $stable(cmd_value))
      else $error("command changed by upper lane");
   unmapped_read_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      cfg_rd_in && !sel_ident && !sel_cmd |=> cfg_rd_data_out == gfc_pkg::ZERO16)
      else $error("unmapped read not zero");
   cmd_read_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      cfg_rd_in && sel_cmd |=>
      (cfg_rd_data_out & ~gfc_pkg::CMD_WRITE_MASK) == gfc_pkg::CMD_FIXED_ONES)
      else $error("command read fixed bits wrong");
endmodule : gfc_regs
`default_nettype wire

// ===== verification/gfc_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module gfc_regs_test;
   localparam logic [15:0] ID_VAL = 16'h3C5A; // Arbitrary value
   logic        clock_in, resetn_in, gfx_mode_in, cfg_wr_in, cfg_rd_in;
   logic [7:0]  cfg_addr_in;
   logic [1:0]  cfg_byte_en_in, cmd_m;
   logic [15:0] cfg_wr_data_in, cfg_rd_data_out, rd_m;
   logic        mem_decode_in, io_decode_in, special_cycle_in, m1, m2, hit;
   logic        cfg_hit_out, mem_claim_out, io_claim_out, master_en_o, scc_o, pre_o;
   logic [31:0] seed;
   int          num_errors, checks_done;
   gfc_regs #(.IDENT_VALUE(ID_VAL)) gfc_regs_inst (.clock_in(clock_in),
      .resetn_in(resetn_in), .gfx_mode_in(gfx_mode_in), .cfg_wr_in(cfg_wr_in),
      .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in), .cfg_byte_en_in(cfg_byte_en_in),
      .cfg_wr_data_in(cfg_wr_data_in), .mem_decode_in(mem_decode_in),
      .io_decode_in(io_decode_in), .special_cycle_in(special_cycle_in),
      .cfg_rd_data_out(cfg_rd_data_out), .cfg_hit_out(cfg_hit_out),
      .mem_claim_out(mem_claim_out), .io_claim_out(io_claim_out),
      .bus_master_enable_out(master_en_o), .special_cycle_claim_out(scc_o),
      .parity_response_enable_out(pre_o));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic results;
      if (num_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   // Reference model
   assign hit = (cfg_rd_in | cfg_wr_in) & m2 &
                (cfg_addr_in == gfc_pkg::IDENT_OFFSET || cfg_addr_in == gfc_pkg::CMD_OFFSET);
   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         {cmd_m, m1, m2, rd_m} = 20'h0;
      end else begin
         if (cfg_rd_in) begin
            rd_m = !hit ? 16'h0000 : (cfg_addr_in == gfc_pkg::IDENT_OFFSET) ? ID_VAL
                 : {14'h0, cmd_m} | 16'h0004;
         end
         if (cfg_wr_in && hit && cfg_addr_in == gfc_pkg::CMD_OFFSET && cfg_byte_en_in[0]) begin
            cmd_m = cfg_wr_data_in[1:0];
         end
         m2 = m1;
         m1 = gfx_mode_in;
      end
   end
   always @(negedge clock_in) begin
      if (resetn_in) begin
         chk(cfg_rd_data_out, rd_m);
         chk({15'h0, cfg_hit_out}, {15'h0, hit});
         chk({14'h0, mem_claim_out, io_claim_out},
             {14'h0, mem_decode_in & cmd_m[1], io_decode_in & cmd_m[0]});
         chk({13'h0, master_en_o, scc_o, pre_o}, 16'h0004);
      end
   end
   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   initial begin
      #(5ns * 4000);
      num_errors++;
      results;
   end
   initial begin
      {resetn_in, gfx_mode_in, cfg_wr_in, cfg_rd_in, cfg_addr_in} = 12'h0;
      {cfg_byte_en_in, cfg_wr_data_in, mem_decode_in, io_decode_in} = 20'h0;
      special_cycle_in = 1'b0;
      seed = 32'd53;
      repeat (12) @(posedge clock_in);
      resetn_in <= 1'b1;
      for (int i = 0; i < 3000; i++) begin
         @(posedge clock_in);
         seed = xorshift(seed);
         resetn_in        <= (i != 1500);
         gfx_mode_in      <= (seed[27:24] != 4'h0);
         cfg_rd_in        <= seed[5];
         cfg_wr_in        <= seed[6];
         cfg_byte_en_in   <= seed[4:3];
         cfg_wr_data_in   <= seed[31:16];
         mem_decode_in    <= seed[7];
         io_decode_in     <= seed[16];
         special_cycle_in <= seed[17];
         cfg_addr_in      <= (seed[2:1] == 2'h0) ? gfc_pkg::IDENT_OFFSET
                           : (seed[2:1] == 2'h3) ? seed[15:8] : gfc_pkg::CMD_OFFSET;
      end
      results;
   end
endmodule : gfc_regs_test
`default_nettype wire
